// ==== rtl/icd_core.sv ====
// input change detector with serial slave port and open-drain alert
// assumes scl period of many core clocks; pins arrive asynchronous
`timescale 1ns/1ps
`include "icd_params.svh"

// Overview of operation
// - inputs compared with snapshot continuously; differences set change flags
// - acknowledge of any own access latches snapshot and clears old flags
// - change flags set regardless of the alert mask
// - flags stay set until next access, even if input returns
// - 8-bit mask selects which changes drive the alert
// - alert not reasserted during a read; waits until stop
// - at stop no alert if changed data already sent
// - slave address is seven bits plus direction, high means read
// - top three address bits fixed at one, one, zero
// - each select pin decodes four ways into two address bits
// - low pin enables pullups on inputs 3..0, high pin on 7..4
// - before first transmission select pins read as static levels
// - one-byte read returns inputs and clears flags and alert
// - second read byte carries flags captured before clearing
// - longer reads alternate data and flags, resampling every pair
// - data byte holds inputs sampled at the preceding acknowledge
// - written byte loads mask; flags and alert cleared
// - every further written byte is acknowledged and reloads mask
// - read address acknowledged and alert released in that ack bit
// - receiver holds sda low through the ninth clock high phase
// - start is sda falling with scl high, stop sda rising
// - power-up sets mask to all ones, flags clear, alert released
// - reset input aborts transaction but keeps mask and alert
module icd_core
    import icd_pkg::*;
#(
    parameter int NUM_INPUTS = 8
) (
    // clock and resets
    input  wire logic                  core_clk,
    input  wire logic                  por_n,
    input  wire logic                  resetn,
    // serial bus
    input  wire logic                  scl_i,
    input  wire logic                  sda_i,
    output logic                       sda_o,
    output logic                       sda_oe,
    // address select straps
    input  wire logic                  addr_select_high_pin,
    input  wire logic                  addr_select_low_pin,
    // monitored inputs and pullup control
    input  wire logic [NUM_INPUTS-1:0] input_pins,
    output logic      [NUM_INPUTS-1:0] pullup_en,
    // alert pin
    output logic                       alert_n_o,
    output logic                       alert_n_oe
);

    generate
        if (NUM_INPUTS != 8) begin : g_bad
            $error("icd_core serves exactly eight inputs");
        end
        if (`ICD_LOW_GROUP * 2 != NUM_INPUTS) begin : g_bad_group
            $error("icd_core pullup groups must split the inputs evenly");
        end
    endgenerate

    // ==========================================================
    // decoding helpers
    // ==========================================================
    function automatic icd_conn_t classify(input icd_watch_t w);
        if (!w.lo_seen) begin
            classify = ICD_CONN_VDD;
        end else if (!w.hi_seen) begin
            classify = ICD_CONN_GND;
        end else if (!w.ne_scl) begin
            classify = ICD_CONN_SCL;
        end else begin
            classify = ICD_CONN_SDA;
        end
    endfunction

    function automatic icd_watch_t watch(input icd_watch_t w, input logic lvl,
                                         input icd_pins_t p);
        watch.hi_seen = w.hi_seen | lvl;
        watch.lo_seen = w.lo_seen | ~lvl;
        watch.ne_scl  = w.ne_scl | (lvl ^ p.scl);
        watch.ne_sda  = w.ne_sda | (lvl ^ p.sda);
    endfunction

    function automatic icd_conn_t static_conn(input logic lvl);
        static_conn = lvl ? ICD_CONN_VDD : ICD_CONN_GND;
    endfunction

    // ==========================================================
    // state
    // ==========================================================
    icd_state_s_t q;
    icd_state_s_t d;
    icd_conn_t    conn_hi;
    icd_conn_t    conn_lo;
    logic [1:0]   code_hi;
    logic [1:0]   code_lo;
    logic [6:0]   own_addr;

    // static levels until a transmission has been seen
    always_comb begin
        conn_hi = q.decoded ? q.conn_hi : static_conn(q.pin_s2.sel_hi);
        conn_lo = q.decoded ? q.conn_lo : static_conn(q.pin_s2.sel_lo);
        case (conn_hi)
            ICD_CONN_SCL: code_hi = `ICD_CODE_ZERO;
            ICD_CONN_SDA: code_hi = `ICD_CODE_ONE;
            ICD_CONN_GND: code_hi = `ICD_CODE_TWO;
            default:      code_hi = `ICD_CODE_THREE;
        endcase
        case (conn_lo)
            ICD_CONN_GND: code_lo = `ICD_CODE_ZERO;
            ICD_CONN_VDD: code_lo = `ICD_CODE_ONE;
            ICD_CONN_SCL: code_lo = `ICD_CODE_TWO;
            default:      code_lo = `ICD_CODE_THREE;
        endcase
        own_addr = {`ICD_ADDR_FIXED, code_hi, code_lo};
    end

    // ==========================================================
    // next state
    // ==========================================================
    always_comb begin
        logic       scl_rise;
        logic       scl_fall;
        logic       start_ev;
        logic       stop_ev;
        logic       grab;
        logic [7:0] diff;
        scl_rise = q.pin_s2.scl & ~q.pin_prev.scl;
        scl_fall = ~q.pin_s2.scl & q.pin_prev.scl;
        start_ev = q.pin_s2.scl & q.pin_prev.scl & ~q.pin_s2.sda & q.pin_prev.sda;
        stop_ev  = q.pin_s2.scl & q.pin_prev.scl & q.pin_s2.sda & ~q.pin_prev.sda;
        grab     = 1'b0;
        diff     = q.in_s2 ^ q.snapshot;
        d        = q;

        // first stage feeds only the second
        d.pin_s1   = {scl_i, sda_i, addr_select_high_pin, addr_select_low_pin};
        d.pin_s2   = q.pin_s1;
        d.pin_prev = q.pin_s2;
        d.in_s1    = input_pins;
        d.in_s2    = q.in_s1;

        // select pins watched from every start, for any target
        if (q.state == ICD_ADDR) begin
            d.watch_hi = watch(q.watch_hi, q.pin_s2.sel_hi, q.pin_s2);
            d.watch_lo = watch(q.watch_lo, q.pin_s2.sel_lo, q.pin_s2);
        end

        // ======================================================
        // bit engine; pins lag the wire by the two sync stages
        // ======================================================
        case (q.state)
            ICD_IDLE: begin
                d.sda_oe = 1'b0;
            end

            ICD_ADDR: begin
                if (scl_rise) begin
                    d.shift   = {q.shift[6:0], q.pin_s2.sda};
                    d.bit_cnt = q.bit_cnt + 4'h1;
                end
                if (scl_fall && q.bit_cnt == `ICD_BYTE_BITS) begin
                    // decode refreshed on every transmission, even a foreign one
                    d.decoded = 1'b1;
                    d.conn_hi = classify(q.watch_hi);
                    d.conn_lo = classify(q.watch_lo);
                    d.bit_cnt = '0;
                    d.rw      = q.shift[0];
                    if (q.shift[7:1] == own_addr) begin
                        d.state    = ICD_ADDR_ACK;
                        d.sda_oe   = 1'b1;
                        grab       = 1'b1;
                        d.read_act = (q.shift[0] == `ICD_DIR_READ);
                    end else begin
                        d.state = ICD_WAIT;
                    end
                end
            end

            ICD_ADDR_ACK: begin
                if (scl_fall) begin
                    if (q.rw == `ICD_DIR_READ) begin
                        d.state      = ICD_TX;
                        d.shift      = q.snapshot;
                        d.sda_oe     = ~q.snapshot[`ICD_BIT_MSB];
                        d.next_flags = 1'b1;
                    end else begin
                        d.state  = ICD_RX;
                        d.sda_oe = 1'b0;
                    end
                end
            end

            ICD_TX: begin
                if (scl_rise) begin
                    d.bit_cnt = q.bit_cnt + 4'h1;
                end
                if (scl_fall) begin
                    if (q.bit_cnt == `ICD_BYTE_BITS) begin
                        // release before the ack clock so the master can answer
                        d.state   = ICD_TX_ACK;
                        d.sda_oe  = 1'b0;
                        d.bit_cnt = '0;
                    end else begin
                        d.shift  = {q.shift[6:0], 1'b0};
                        d.sda_oe = ~q.shift[6];
                    end
                end
            end

            ICD_TX_ACK: begin
                if (scl_rise) begin
                    d.acked = ~q.pin_s2.sda;
                    // data byte follows: resample at this ack
                    if (!q.pin_s2.sda && !q.next_flags) begin
                        grab = 1'b1;
                    end
                end
                if (scl_fall) begin
                    if (q.acked) begin
                        d.state      = ICD_TX;
                        d.shift      = q.next_flags ? q.flags_cap : q.snapshot;
                        d.sda_oe     = q.next_flags ? ~q.flags_cap[`ICD_BIT_MSB]
                                                    : ~q.snapshot[`ICD_BIT_MSB];
                        d.next_flags = ~q.next_flags;
                    end else begin
                        d.state = ICD_WAIT;
                    end
                end
            end

            ICD_RX: begin
                if (scl_rise) begin
                    d.shift   = {q.shift[6:0], q.pin_s2.sda};
                    d.bit_cnt = q.bit_cnt + 4'h1;
                end
                if (scl_fall && q.bit_cnt == `ICD_BYTE_BITS) begin
                    d.state   = ICD_RX_ACK;
                    d.sda_oe  = 1'b1;
                    // mask taken at the byte end, before the ack is clocked
                    d.mask    = q.shift;
                    d.bit_cnt = '0;
                end
            end

            ICD_RX_ACK: begin
                if (scl_fall) begin
                    d.state  = ICD_RX;
                    d.sda_oe = 1'b0;
                end
            end

            default: begin
                d.sda_oe = 1'b0;
            end
        endcase

        // ======================================================
        // bus conditions override the bit engine
        // ======================================================
        // repeated start restarts address phase
        if (start_ev) begin
            d.state    = ICD_ADDR;
            d.bit_cnt  = '0;
            d.sda_oe   = 1'b0;
            d.read_act = 1'b0;
            d.watch_hi = '0;
            d.watch_lo = '0;
        end
        // a change seen after the last resample alerts here
        if (stop_ev) begin
            d.state    = ICD_IDLE;
            d.sda_oe   = 1'b0;
            d.read_act = 1'b0;
        end

        // ======================================================
        // change flags
        // ======================================================
        // flags: a change in the grab cycle lands in the new snapshot
        if (grab) begin
            d.snapshot  = q.in_s2;
            d.flags_cap = q.flags | diff;
            d.flags     = '0;
        end else begin
            d.flags = q.flags | diff;
        end

        // ======================================================
        // bus reset and alert
        // ======================================================
        // bus abort only; mask, flags and alert survive
        if (!resetn) begin
            d.state    = ICD_IDLE;
            d.sda_oe   = 1'b0;
            d.bit_cnt  = '0;
            d.read_act = 1'b0;
            d.acked    = 1'b0;
        end

        d.alert = (|(d.flags & d.mask)) & ~d.read_act;
    end

    // ==========================================================
    // register update; power-up is the only full clear
    // ==========================================================
    always_ff @(posedge core_clk) begin
        if (!por_n) begin
            q          <= '0;
            q.pin_s1   <= '1;
            q.pin_s2   <= '1;
            q.pin_prev <= '1;
            q.mask     <= `ICD_MASK_RESET;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // outputs
    // ==========================================================
    assign sda_o      = 1'b0;
    assign sda_oe     = q.sda_oe;
    assign alert_n_o  = 1'b0;
    assign alert_n_oe = q.alert;

    // ground strap disables a group, anything seen high enables it
    genvar gi;
    generate
        for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_pull
            if (gi < `ICD_LOW_GROUP) begin : g_lo
                assign pullup_en[gi] = (conn_lo != ICD_CONN_GND);
            end else begin : g_hi
                assign pullup_en[gi] = (conn_hi != ICD_CONN_GND);
            end
        end
    endgenerate

endmodule

// ==== inc/icd_params.svh ====
// constants for the input change detector with its serial slave port
// assumes a core clock far faster than the serial clock
`ifndef ICD_PARAMS_SVH
`define ICD_PARAMS_SVH
`define ICD_ADDR_FIXED   3'h6
`define ICD_MASK_RESET   8'hFF
`define ICD_BYTE_BITS    4'h8
`define ICD_BIT_MSB      3'h7
`define ICD_CODE_ZERO    2'h0
`define ICD_CODE_ONE     2'h1
`define ICD_CODE_TWO     2'h2
`define ICD_CODE_THREE   2'h3
`define ICD_DIR_READ     1'h1
`define ICD_LOW_GROUP    4
`endif

// ==== inc/icd_pkg.sv ====
// types of the input change detector
// assumes icd_params.svh for the numeric constants
package icd_pkg;
    typedef enum logic [2:0] {
        ICD_IDLE     = 3'b000,
        ICD_ADDR     = 3'b001,
        ICD_ADDR_ACK = 3'b010,
        ICD_TX       = 3'b011,
        ICD_TX_ACK   = 3'b100,
        ICD_RX       = 3'b101,
        ICD_RX_ACK   = 3'b110,
        ICD_WAIT     = 3'b111
    } icd_state_t;

    typedef enum logic [1:0] {
        ICD_CONN_GND = 2'b00,
        ICD_CONN_VDD = 2'b01,
        ICD_CONN_SCL = 2'b10,
        ICD_CONN_SDA = 2'b11
    } icd_conn_t;

    // pin levels as sampled: clock, data, high select, low select
    typedef struct packed {
        logic scl;
        logic sda;
        logic sel_hi;
        logic sel_lo;
    } icd_pins_t;

    // what one select pin has shown since start
    typedef struct packed {
        logic hi_seen;
        logic lo_seen;
        logic ne_scl;
        logic ne_sda;
    } icd_watch_t;

    typedef struct packed {
        icd_pins_t  pin_s1;
        icd_pins_t  pin_s2;
        icd_pins_t  pin_prev;
        logic [7:0] in_s1;
        logic [7:0] in_s2;
        icd_state_t state;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic       rw;
        logic       acked;
        logic       next_flags;
        logic       read_act;
        logic       sda_oe;
        icd_watch_t watch_hi;
        icd_watch_t watch_lo;
        logic       decoded;
        icd_conn_t  conn_hi;
        icd_conn_t  conn_lo;
        logic [7:0] snapshot;
        logic [7:0] flags;
        logic [7:0] flags_cap;
        logic [7:0] mask;
        logic       alert;
    } icd_state_s_t;
endpackage

// ==== test/icd_core_sva.sv ====
// port checker for the input change detector
// assumes binding onto icd_core with the bus wires already resolved
`timescale 1ns/1ps
module icd_core_sva
    import icd_pkg::*;
#(
    parameter int NUM_INPUTS = 8
) (
    // clock and resets
    input wire logic                  core_clk,
    input wire logic                  por_n,
    input wire logic                  resetn,
    // serial bus
    input wire logic                  scl_i,
    input wire logic                  sda_i,
    input wire logic                  sda_o,
    input wire logic                  sda_oe,
    // pullups and alert
    input wire logic [NUM_INPUTS-1:0] pullup_en,
    input wire logic                  alert_n_o,
    input wire logic                  alert_n_oe
);
    // ========
    // frame tracking on the raw pins, ahead of the device's own sync
    logic       scl_q;
    logic       sda_q;
    logic       busy_q;
    logic [3:0] rise_q;
    logic [7:0] shift_q;
    wire        both_hi = scl_i && scl_q;
    always_ff @(posedge core_clk) begin
        scl_q <= scl_i;
        sda_q <= sda_i;
        if (scl_i && !scl_q) begin
            shift_q <= {shift_q[6:0], sda_i};
            rise_q  <= (rise_q == 4'hF) ? rise_q : rise_q + 4'h1;
        end
        if (both_hi && sda_q && !sda_i) begin
            rise_q <= 4'h0;
            busy_q <= 1'h1;
        end
        if (!por_n || (both_hi && !sda_q && sda_i)) begin
            busy_q <= 1'h0;
        end
    end
    // ========
    // assertions
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!por_n);
    AST_SDA_OPEN_DRAIN: assert property (sda_o == 1'h0)
        else $error("sda output not low");
    AST_ALERT_OPEN_DRAIN: assert property (alert_n_o == 1'h0)
        else $error("alert output not low");
    AST_PULLUP_GROUPS: assert property (pullup_en[3:0] inside {4'h0, 4'hF}
        && pullup_en[7:4] inside {4'h0, 4'hF}) else $error("pullup group split");
    AST_BUS_RESET: assert property (!resetn |=> !sda_oe)
        else $error("sda held after bus reset");
    AST_POWER_UP: assert property ($rose(por_n) |-> !alert_n_oe && !sda_oe)
        else $error("output active at power-up");
    AST_STABLE_HIGH: assert property (disable iff (!por_n || !resetn)
        scl_i && $past(scl_i) |-> $stable(sda_oe)) else $error("sda moved in high phase");
    AST_ONLY_IN_FRAME: assert property (sda_oe |-> busy_q)
        else $error("sda driven outside a frame");
    AST_ACK_PREFIX: assert property ($rose(scl_i) && rise_q == 4'h8 && sda_oe
        |-> shift_q[7:5] == 3'h6) else $error("ack to foreign prefix");
    AST_ACK_CLEARS_ALERT: assert property ($rose(scl_i) && rise_q == 4'h8 && sda_oe
        |-> ##2 !alert_n_oe) else $error("alert kept over address ack");
endmodule
bind icd_core icd_core_sva #(.NUM_INPUTS(NUM_INPUTS)) u_sva (
    .core_clk(core_clk), .por_n(por_n), .resetn(resetn), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .pullup_en(pullup_en),
    .alert_n_o(alert_n_o), .alert_n_oe(alert_n_oe)
);

// ==== test/icd_i2c_master.sv ====
// serial bus master model: makes the bus clock, pulls data low
// assumes a pulled-up data wire resolved by the bench
`timescale 1ns/1ps
module icd_i2c_master (
    // clock
    input  wire logic core_clk,
    // bus wires
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    // ========
    // bus clock stands high outside frames
    initial begin
        scl     = 1'h1;
        sda_low = 1'h0;
    end
    // data set after the fall, held through the high phase
    task automatic bus_bit(input logic b, output logic r);
        @(posedge core_clk) sda_low <= !b;
        repeat (3) @(posedge core_clk);
        scl <= 1'h1;
        repeat (2) @(posedge core_clk);
        r = sda;
        repeat (2) @(posedge core_clk);
        scl <= 1'h0;
    endtask
    task automatic bus_byte(input logic [7:0] d, input logic ack, output logic [8:0] q);
        logic [8:0] w;
        w = {d, ack};
        for (int i = 8; i >= 0; i--) begin
            bus_bit(w[i], q[i]);
        end
    endtask
    task automatic bus_start();
        @(posedge core_clk) sda_low <= 1'h1;
        repeat (4) @(posedge core_clk);
        scl <= 1'h0;
    endtask
    task automatic bus_stop();
        @(posedge core_clk) sda_low <= 1'h1;
        repeat (3) @(posedge core_clk);
        scl <= 1'h1;
        repeat (4) @(posedge core_clk);
        sda_low <= 1'h0;
        repeat (4) @(posedge core_clk);
    endtask
endmodule

// ==== test/icd_core_tb.sv ====
// self-checking bench for the input change detector
// assumes the master model and the bound port checker
`timescale 1ns/1ps
`define CHK_EQ(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("ERROR %0t got %h want %h", $time, got, exp); end end
module icd_core_tb
    import icd_pkg::*;
;
    localparam logic [6:0] ADDR_A = 7'h69;
    localparam logic [6:0] ADDR_B = 7'h66;
    logic       core_clk = 1'h0;
    logic       por_n;
    logic       resetn;
    logic [7:0] pins;
    logic [8:0] r;
    icd_conn_t  hi_conn;
    icd_conn_t  lo_conn;
    int         n_fail = 0;
    int         total_checks = 0;
    wire        scl, sda_low, sda_o, sda_oe, alert_n_o, alert_n_oe;
    wire  [7:0] pullup_en;
    // ========
    // pulled-up data wire; straps follow their chosen connection
    wire        sda = !(sda_low || sda_oe);
    wire        sel_hi = (hi_conn == ICD_CONN_SCL) ? scl : (hi_conn == ICD_CONN_SDA) ? sda
                         : hi_conn[0];
    wire        sel_lo = (lo_conn == ICD_CONN_SCL) ? scl : (lo_conn == ICD_CONN_SDA) ? sda
                         : lo_conn[0];
    icd_core #(.NUM_INPUTS(8)) u_dut (
        .core_clk(core_clk), .por_n(por_n), .resetn(resetn), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .addr_select_high_pin(sel_hi),
        .addr_select_low_pin(sel_lo), .input_pins(pins), .pullup_en(pullup_en),
        .alert_n_o(alert_n_o), .alert_n_oe(alert_n_oe)
    );
    icd_i2c_master u_mst (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
    always #10 core_clk = ~core_clk;
    // ========
    // helpers
    task automatic print_verdict();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // bounded wait for the alert level; a hang ends the run
    task automatic settle(input logic lvl);
        for (int i = 0; i < 12 && alert_n_oe !== lvl; i++) @(posedge core_clk);
        `CHK_EQ(alert_n_oe, lvl)
        if (alert_n_oe !== lvl) print_verdict();
    endtask
    // ========
    // scenarios
    task automatic sc_read_stream();
        pins <= 8'hA5;
        settle(1'h1);
        u_mst.bus_start();
        u_mst.bus_byte({ADDR_A, 1'h1}, 1'h1, r);
        `CHK_EQ(r[0], 1'h0)
        `CHK_EQ(alert_n_oe, 1'h0)
        u_mst.bus_byte(8'hFF, 1'h0, r);
        `CHK_EQ(r[8:1], 8'hA5)
        pins <= 8'h3C;
        repeat (10) @(posedge core_clk);
        `CHK_EQ(alert_n_oe, 1'h0)
        u_mst.bus_byte(8'hFF, 1'h0, r);
        `CHK_EQ(r[8:1], 8'hA5)
        u_mst.bus_byte(8'hFF, 1'h1, r);
        `CHK_EQ(r[8:1], 8'h3C)
        u_mst.bus_stop();
        repeat (10) @(posedge core_clk);
        `CHK_EQ(alert_n_oe, 1'h0)
    endtask
    task automatic sc_mask_write();
        u_mst.bus_start();
        u_mst.bus_byte({ADDR_A, 1'h0}, 1'h1, r);
        u_mst.bus_byte(8'h00, 1'h1, r);
        `CHK_EQ(r[0], 1'h0)
        u_mst.bus_byte(8'h0F, 1'h1, r);
        `CHK_EQ(r[0], 1'h0)
        u_mst.bus_stop();
        pins <= 8'hBC;
        repeat (10) @(posedge core_clk);
        `CHK_EQ(alert_n_oe, 1'h0)
        pins <= 8'h3D;
        settle(1'h1);
        u_mst.bus_start();
        u_mst.bus_byte({ADDR_A, 1'h1}, 1'h1, r);
        u_mst.bus_byte(8'hFF, 1'h0, r);
        `CHK_EQ(r[8:1], 8'h3D)
        u_mst.bus_byte(8'hFF, 1'h1, r);
        `CHK_EQ(r[8:1], 8'h81)
        u_mst.bus_stop();
        `CHK_EQ(alert_n_oe, 1'h0)
    endtask
    task automatic sc_straps();
        hi_conn <= ICD_CONN_SDA;
        lo_conn <= ICD_CONN_SCL;
        u_mst.bus_start();
        u_mst.bus_byte({7'h50, 1'h0}, 1'h1, r);
        `CHK_EQ(r[0], 1'h1)
        u_mst.bus_stop();
        `CHK_EQ(pullup_en, 8'hFF)
        u_mst.bus_start();
        u_mst.bus_byte({ADDR_B, 1'h1}, 1'h1, r);
        `CHK_EQ(r[0], 1'h0)
        u_mst.bus_byte(8'hFF, 1'h1, r);
        `CHK_EQ(r[8:1], 8'h3D)
        u_mst.bus_stop();
    endtask
    task automatic sc_bus_reset();
        u_mst.bus_start();
        u_mst.bus_byte({ADDR_B, 1'h1}, 1'h1, r);
        resetn <= 1'h0;
        @(posedge core_clk) resetn <= 1'h1;
        repeat (6) @(posedge core_clk);
        `CHK_EQ(sda_oe, 1'h0)
        u_mst.bus_stop();
        pins <= 8'h2D;
        repeat (10) @(posedge core_clk);
        `CHK_EQ(alert_n_oe, 1'h0)
        pins <= 8'h2C;
        settle(1'h1);
    endtask
    // ========
    // main sequence and hang guard
    initial begin
        por_n   = 1'h0;
        resetn  = 1'h0;
        pins    = 8'h00;
        hi_conn = ICD_CONN_GND;
        lo_conn = ICD_CONN_VDD;
        repeat (16) @(posedge core_clk);
        por_n  <= 1'h1;
        resetn <= 1'h1;
        repeat (6) @(posedge core_clk);
        `CHK_EQ(alert_n_oe, 1'h0)
        `CHK_EQ(pullup_en, 8'h0F)
        sc_read_stream();
        sc_mask_write();
        sc_straps();
        sc_bus_reset();
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        print_verdict();
    end
endmodule
